// >>> src/dca_cfg.svh
// Purpose: Constants for the drive command arbiter and interlock block.
// Assumes: 125 MHz clock, APB register access with 32-bit data.
// Notes:   Every offset, the config and event field positions, and the reset values of the four setting registers live here.
`ifndef DCA_CFG_SVH
`define DCA_CFG_SVH
// Register byte addresses.
`define DCA_CFG_ADDR      12'h000
`define DCA_DECEL_ADDR    12'h004
`define DCA_FLOOR_ADDR    12'h008
`define DCA_JOG_ADDR      12'h00C
`define DCA_STATUS_ADDR   12'h010
`define DCA_EVENT_ADDR    12'h014
`define DCA_MASK_ADDR     12'h018
`define DCA_FREQ_ADDR     12'h01C
// Configuration field positions.
`define DCA_LINK_SEL_LSB  0
`define DCA_REGEN_BIT     2
`define DCA_STOP_SEL_LSB  3
`define DCA_HW_LIM_BIT    5
`define DCA_SW_LIM_LSB    8
// Overload decel codes, hundredths of Hz per second.
`define DCA_OLD_USE_TIMES 16'h0000
`define DCA_OLD_MAX_RATE  16'h2710
`define DCA_OLD_DISABLE   16'h9B1C
// Floor limit, tenths of Hz (60.0 Hz).
`define DCA_FLOOR_MAX     16'h0258
// Jog ramp limit, hundredths of a second (3600 s).
`define DCA_JOG_MAX       20'h57E40
// Reset values. Start check is on from reset, so a run held through
// power-up is refused rather than starting the motor unasked.
`define DCA_CFG_RST       16'h0010
`define DCA_DECEL_RST     16'h9B1C
`define DCA_FLOOR_RST     16'h0000
`define DCA_JOG_RST       20'h003E8
// Stretch and torque factors applied under regen suppression.
`define DCA_REGEN_STRETCH 3
// Interlock error code shown on the display.
`define DCA_ERR_CODE      8'h06
// Event bit positions.
`define DCA_EV_INTERLOCK  0
`define DCA_EV_OVERVOLT   1
`define DCA_EV_STOPKEY    2
`define DCA_EV_OVERLOAD   3
`endif

// >>> src/dca_pkg.sv
// Purpose: Types for the drive command arbiter and interlock block.
// Assumes: Used together with dca_cfg.svh.
// Notes:   Holds only types; numbers live in the header.
package dca_pkg;
  // Where the run and frequency commands are taken from.
  typedef enum logic [1:0] {DCA_SRC_KEYPAD, DCA_SRC_TERM, DCA_SRC_LINK}
    dca_src_t;
  // Decel mode selected for the ramp generator.
  typedef enum logic [1:0] {DCA_DEC_NORMAL, DCA_DEC_TIMES, DCA_DEC_RATE,
    DCA_DEC_REGEN} dca_dec_t;
  // Run command set from one source.
  typedef struct packed {
    logic fwd;
    logic rev;
  } dca_run_t;
  // Decoded grants of the link function selector.
  typedef struct packed {
    logic monitor;
    logic freq;
    logic oper;
  } dca_grant_t;
endpackage

// >>> src/dca_arbiter.sv
// Purpose: Run/frequency source arbitration, stop-key and start interlock,
//          decel-rate selection for regen and overload suppression.
// Assumes: All inputs synchronous to clk; APB slave for registers.
// Notes:   Analog stage and ramp generator are outside; this block steers.
//
// Functional notes
// - Link always monitors; selector grants freq/operation
// - Link-enable input activates the selected link rights
// - Link disabled: commands from terminals or keypad only
// - Regen suppression: triple decel time, third torque
// - Excess regen energy: output off, overvoltage alarm
// - Overload decel code: times, fixed rate, or off
// - Overload suppression decelerates on temperature alarm level
// - Current limiting enabled keeps overload suppression off
// - Limiters acting: output frequency held above floor
// - One jog ramp time for accel and decel
// - Stop/start selector decodes stop priority, start check
// - Stop key on remote source forces stop, error 6
// - Start check refuses start with run asserted
// - Start check at power-up
// - Start check on alarm reset with run asserted
// - Start check on link source switch with run
`timescale 1ns/10ps
`include "dca_cfg.svh"
module dca_arbiter
  import dca_pkg::*;
(
  input  wire logic        clk,               // System clock, 125 MHz.
  input  wire logic        sys_rst,           // Synchronous reset, high.
  input  wire logic        psel,              // APB select.
  input  wire logic        penable,           // APB access phase.
  input  wire logic        pwrite,            // APB direction.
  input  wire logic [11:0] paddr,             // APB byte address.
  input  wire logic [31:0] pwdata,            // APB write data.
  output logic             pready,            // APB ready.
  output logic      [31:0] prdata,            // APB read data.
  output logic             pslverr,           // APB error.
  input  wire logic        link_enable_input, // Link enable, resolved.
  input  wire dca_run_t    link_run,          // Run from the serial link.
  input  wire logic [15:0] link_freq,         // Frequency from the link.
  input  wire dca_run_t    term_run,          // Run from terminals.
  input  wire logic [15:0] term_freq,         // Frequency from terminals.
  input  wire dca_run_t    key_run,           // Run from keypad.
  input  wire logic [15:0] key_freq,          // Frequency from keypad.
  input  wire logic        term_is_source,    // Terminals own run, not pad.
  input  wire logic        stop_key,          // Keypad stop pressed.
  input  wire logic        alarm_reset,       // Keypad or input reset.
  input  wire logic        regen_overenergy,  // Regen beyond capacity.
  input  wire logic        bus_over_level,    // DC bus over suppress level.
  input  wire logic        temp_alarm_level,  // Any temperature over level.
  input  wire logic        limiter_acting,    // Current limiter acting.
  input  wire logic        jog_active,        // Jogging operation.
  output logic             link_freq_grant,   // Link may set frequency.
  output logic             link_oper_grant,   // Link may command run.
  output dca_run_t         run_out,           // Run to the drive.
  output logic      [15:0] freq_out,          // Frequency to the drive.
  output logic             output_off,        // Output shut down.
  output dca_dec_t         decel_mode,        // Decel selection.
  output logic      [15:0] decel_rate,        // Fixed rate when selected.
  output logic      [19:0] ramp_time,         // Jog ramp, when jogging.
  output logic       [1:0] torque_div,        // Decel torque divisor.
  output logic       [7:0] err_code,          // Display error code.
  output logic             irq                // Level interrupt.
);

  // Software-written settings and internal state.
  logic [15:0] cfg_q;                    // Selectors and current limit.
  logic [15:0] decel_q;                  // Overload decel code.
  logic [15:0] floor_q;                  // Frequency floor.
  logic [19:0] jog_q;                    // Jog ramp time.
  logic  [3:0] event_q;                  // Sticky events.
  logic  [3:0] mask_q;                   // Interrupt mask.
  logic        interlock_q;              // Start interlock latched.
  logic        stopped_q;                // Stop-key stop latched.
  logic        ov_alarm_q;               // Overvoltage alarm latched.
  logic        link_en_q;                // Previous link-enable.
  logic        pwr_up_q;                 // First cycle after reset.
  logic  [3:0] ev_set;                   // Event pulses this cycle.

  // Grants from the selector value.
  function automatic dca_grant_t grant_of(input logic [1:0] sel);
    dca_grant_t g;
    g.monitor = 1'b1;
    g.freq    = sel[0];
    g.oper    = sel[1];
    return g;
  endfunction

  // True when any run command bit of a set is on.
  function automatic logic any_run(input dca_run_t r);
    return r.fwd | r.rev;
  endfunction

  dca_grant_t grant;                     // Link grants in force.
  logic       stop_pri;                  // Stop-key priority enabled.
  logic       start_chk;                 // Start check enabled.
  logic       cur_lim_on;                // Current limiting enabled.
  logic       ovl_on;                    // Overload suppression live.
  dca_src_t   run_src;                   // Selected run source.
  dca_run_t   sel_run;                   // Run at the selected source.
  logic       chk_event;                 // A checked event occurs.

  // Decode selectors. Monitoring needs no gate so it is not exported.
  always_comb
  begin
    grant      = grant_of(cfg_q[`DCA_LINK_SEL_LSB +: 2]);
    stop_pri   = cfg_q[`DCA_STOP_SEL_LSB];
    start_chk  = cfg_q[`DCA_STOP_SEL_LSB + 1];
    cur_lim_on = (cfg_q[`DCA_SW_LIM_LSB +: 8] != 8'h00)
                 && cfg_q[`DCA_HW_LIM_BIT];
    ovl_on     = (decel_q != `DCA_OLD_DISABLE) && !cur_lim_on;
  end

  // Link rights only apply while link-enable is active.
  assign link_freq_grant = link_enable_input & grant.freq;
  assign link_oper_grant = link_enable_input & grant.oper;

  // Choose the run source; link ignored while link-enable is off.
  always_comb
  begin
    if (link_oper_grant)
    begin
      run_src = DCA_SRC_LINK;
      sel_run = link_run;
    end
    else if (term_is_source)
    begin
      run_src = DCA_SRC_TERM;
      sel_run = term_run;
    end
    else
    begin
      run_src = DCA_SRC_KEYPAD;
      sel_run = key_run;
    end
  end

  // Checked events: power-up, alarm reset, source switch by link-enable.
  always_comb
  begin
    chk_event = pwr_up_q
              | alarm_reset
              | ((link_enable_input != link_en_q)
                 && grant.oper);
  end

  // Power-up marker and link-enable history.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pwr_up_q  <= 1'b1;
      link_en_q <= 1'b0;
    end
    else
    begin
      pwr_up_q  <= 1'b0;
      link_en_q <= link_enable_input;
    end
  end

  // Start interlock latches on a checked event with run on, and clears
  // only once every run at the active source is released.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      interlock_q <= 1'b0;
    else if (start_chk && chk_event && any_run(sel_run))
      interlock_q <= 1'b1;
    else if (!any_run(sel_run))
      interlock_q <= 1'b0;
  end

  // Stop key wins over terminal or link run; held until run released.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      stopped_q <= 1'b0;
    else if (stop_pri && stop_key && run_src != DCA_SRC_KEYPAD)
      stopped_q <= 1'b1;
    else if (!any_run(sel_run))
      stopped_q <= 1'b0;
  end

  // Overvoltage alarm shuts the output until an alarm reset.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ov_alarm_q <= 1'b0;
    else if (regen_overenergy)
      ov_alarm_q <= 1'b1;
    else if (alarm_reset)
      ov_alarm_q <= 1'b0;
  end

  // Drive outputs registered: run gated, frequency with floor.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      run_out    <= '0;
      freq_out   <= 16'h0000;
      output_off <= 1'b0;
      err_code   <= 8'h00;
    end
    else
    begin
      output_off <= ov_alarm_q | regen_overenergy;
      // The check hit itself gates too, so no run leaks for one cycle.
      if (interlock_q || stopped_q || ov_alarm_q
          || ev_set[`DCA_EV_INTERLOCK])
        run_out <= '0;
      else
        run_out <= sel_run;
      if ((limiter_acting || (ovl_on && temp_alarm_level))
          && (link_freq_grant ? link_freq
              : (term_is_source ? term_freq : key_freq)) < floor_q)
        freq_out <= floor_q;
      else if (link_freq_grant)
        freq_out <= link_freq;
      else
        freq_out <= term_is_source ? term_freq : key_freq;
      err_code <= (interlock_q || stopped_q) ? `DCA_ERR_CODE
                                             : 8'h00;
    end
  end

  // Decel selection; regen stretch beats overload rate when both apply.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      decel_mode <= DCA_DEC_NORMAL;
      decel_rate <= 16'h0000;
      torque_div <= 2'd1;
      ramp_time  <= 20'h00000;
    end
    else
    begin
      ramp_time <= jog_active ? jog_q : 20'h00000;
      if (cfg_q[`DCA_REGEN_BIT] && bus_over_level)
      begin
        decel_mode <= DCA_DEC_REGEN;
        torque_div <= 2'(`DCA_REGEN_STRETCH);
        decel_rate <= 16'h0000;
      end
      else if (ovl_on && temp_alarm_level)
      begin
        torque_div <= 2'd1;
        if (decel_q == `DCA_OLD_USE_TIMES)
        begin
          decel_mode <= DCA_DEC_TIMES;
          decel_rate <= 16'h0000;
        end
        else
        begin
          decel_mode <= DCA_DEC_RATE;
          decel_rate <= decel_q;
        end
      end
      else
      begin
        decel_mode <= DCA_DEC_NORMAL;
        decel_rate <= 16'h0000;
        torque_div <= 2'd1;
      end
    end
  end

  // Event pulses feeding sticky status bits.
  always_comb
  begin
    ev_set = '0;
    ev_set[`DCA_EV_INTERLOCK] = start_chk && chk_event && any_run(sel_run);
    ev_set[`DCA_EV_OVERVOLT]  = regen_overenergy && !ov_alarm_q;
    ev_set[`DCA_EV_STOPKEY]   = stop_pri && stop_key
                                && run_src != DCA_SRC_KEYPAD;
    ev_set[`DCA_EV_OVERLOAD]  = ovl_on && temp_alarm_level;
  end

  // APB: zero-wait slave; unmapped addresses answer with an error.
  logic apb_acc;                         // Access phase this cycle.
  logic mapped;                          // Address hits a register.
  assign apb_acc = psel & penable;
  assign pready  = 1'b1;
  always_comb
  begin
    mapped = 1'b1;
    case (paddr)
      `DCA_CFG_ADDR:    prdata = {16'h0000, cfg_q};
      `DCA_DECEL_ADDR:  prdata = {16'h0000, decel_q};
      `DCA_FLOOR_ADDR:  prdata = {16'h0000, floor_q};
      `DCA_JOG_ADDR:    prdata = {12'h000, jog_q};
      `DCA_STATUS_ADDR: prdata = {24'h000000, err_code[3:0], ov_alarm_q,
                                  stopped_q, interlock_q, link_en_q};
      `DCA_EVENT_ADDR:  prdata = {28'h0000000, event_q};
      `DCA_MASK_ADDR:   prdata = {28'h0000000, mask_q};
      `DCA_FREQ_ADDR:   prdata = {16'h0000, freq_out};
      default:
      begin
        prdata = 32'h00000000;
        mapped = 1'b0;
      end
    endcase
    pslverr = apb_acc & ~mapped;
  end

  // Register writes; floor and jog are clamped, an out-of-range decel code becomes the disable code.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cfg_q   <= `DCA_CFG_RST;
      decel_q <= `DCA_DECEL_RST;
      floor_q <= `DCA_FLOOR_RST;
      jog_q   <= `DCA_JOG_RST;
      mask_q  <= 4'h0;
    end
    else if (apb_acc && pwrite)
    begin
      case (paddr)
        `DCA_CFG_ADDR:   cfg_q <= pwdata[15:0];
        `DCA_DECEL_ADDR:
          decel_q <= (pwdata[15:0] > `DCA_OLD_MAX_RATE)
                     ? `DCA_OLD_DISABLE : pwdata[15:0];
        `DCA_FLOOR_ADDR:
          floor_q <= (pwdata[15:0] > `DCA_FLOOR_MAX)
                     ? `DCA_FLOOR_MAX : pwdata[15:0];
        `DCA_JOG_ADDR:
          jog_q <= (pwdata[19:0] > `DCA_JOG_MAX)
                   ? `DCA_JOG_MAX : pwdata[19:0];
        `DCA_MASK_ADDR:  mask_q <= pwdata[3:0];
        default:         cfg_q <= cfg_q;
      endcase
    end
  end

  // Sticky events; a read clears, but a same-cycle set wins.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      event_q <= 4'h0;
    else if (apb_acc && !pwrite && paddr == `DCA_EVENT_ADDR)
      event_q <= ev_set;
    else
      event_q <= event_q | ev_set;
  end

  assign irq = |(event_q & mask_q);

  // Assertions.
  a_interlock_blocks: assert property (@(posedge clk) disable iff (sys_rst)
    interlock_q |=> run_out == '0 && err_code == `DCA_ERR_CODE)
    else $error("Run passed while interlocked.");
  a_powerup_check: assert property (@(posedge clk) disable iff (sys_rst)
    pwr_up_q && start_chk && any_run(sel_run)
    |=> interlock_q && run_out == '0)
    else $error("Power-up start check missed.");
  a_reset_check: assert property (@(posedge clk) disable iff (sys_rst)
    alarm_reset && start_chk && any_run(sel_run) |=> interlock_q)
    else $error("Alarm reset start check missed.");
  a_switch_check: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(link_enable_input) && grant.oper && start_chk
    && any_run(sel_run) |=> interlock_q && run_out == '0)
    else $error("Source switch start check missed.");
  a_interlock_hold: assert property (@(posedge clk) disable iff (sys_rst)
    interlock_q && any_run(sel_run) |=> interlock_q)
    else $error("Interlock released early.");
  a_stop_key: assert property (@(posedge clk) disable iff (sys_rst)
    stop_pri && stop_key && run_src != DCA_SRC_KEYPAD
    |=> ##1 run_out == '0)
    else $error("Stop key did not stop.");
  a_link_gate: assert property (@(posedge clk) disable iff (sys_rst)
    !link_enable_input |-> !link_oper_grant && !link_freq_grant)
    else $error("Link rights while disabled.");
  a_overvolt_off: assert property (@(posedge clk) disable iff (sys_rst)
    regen_overenergy |=> output_off ##1 output_off)
    else $error("Output not shut on overvoltage.");
  a_regen_stretch: assert property (@(posedge clk) disable iff (sys_rst)
    cfg_q[`DCA_REGEN_BIT] && bus_over_level
    |=> decel_mode == DCA_DEC_REGEN && torque_div == 2'd3)
    else $error("Regen stretch not applied.");
  a_limit_blocks_ovl: assert property (@(posedge clk) disable iff (sys_rst)
    cur_lim_on && !(cfg_q[`DCA_REGEN_BIT] && bus_over_level)
    |=> decel_mode == DCA_DEC_NORMAL)
    else $error("Overload suppression with limiter on.");

  c_interlock: cover property (@(posedge clk) disable iff (sys_rst)
    interlock_q ##1 !interlock_q);
  c_stop_key: cover property (@(posedge clk) disable iff (sys_rst)
    $rose(stopped_q));
  c_overload: cover property (@(posedge clk) disable iff (sys_rst)
    decel_mode == DCA_DEC_RATE);
  c_irq: cover property (@(posedge clk) disable iff (sys_rst) $rose(irq));
endmodule

// >>> tb/dca_link_host.sv
// Purpose: Behavioural serial-link host that sends run and frequency words.
// Assumes: The bench asks for a word just after a rising edge.
// Notes:   Words are registered, so the link shows them one edge later.
`timescale 1ns/10ps
module dca_link_host
  import dca_pkg::*;
(
  input  wire logic        clk,       // System clock.
  input  wire logic        sys_rst,   // Synchronous reset, high.
  input  wire dca_run_t    want_run,  // Run word the host wants to send.
  input  wire logic [15:0] want_freq, // Frequency the host wants to send.
  output dca_run_t         link_run,  // Run word on the link.
  output logic      [15:0] link_freq  // Frequency word on the link.
);
  // The host drops its run at reset, so no stale command can start a motor.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      link_run  <= 2'h0;
      link_freq <= 16'h0000;
    end
    else
    begin
      link_run  <= want_run;
      link_freq <= want_freq;
    end
  end
endmodule

// >>> tb/drive_command_arbiter_interlock_tb.sv
// Purpose: Self-checking bench for the command arbiter and interlock.
// Assumes: Zero-wait APB slave; outputs settle within three edges.
// Notes:   Interlock runs first so the event register starts clean.
`timescale 1ns/10ps
`include "dca_cfg.svh"
module drive_command_arbiter_interlock_tb
  import dca_pkg::*;
;
  logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, perr;
  logic        link_enable_input, term_is_source, stop_key, alarm_reset;
  logic        regen_overenergy, bus_over_level, temp_alarm_level;
  logic        limiter_acting, jog_active, link_freq_grant, link_oper_grant;
  logic        output_off, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [15:0] link_freq, term_freq, key_freq, want_freq, freq_out;
  logic [15:0] decel_rate;
  logic [19:0] ramp_time;
  logic  [1:0] torque_div;
  logic  [7:0] err_code;
  dca_run_t    link_run, term_run, key_run, want_run, run_out;
  dca_dec_t    decel_mode;
  int          n_errors, n_checks;

  dca_arbiter uut (.*);
  dca_link_host host (.*);

  // The clock toggles every half period of 4 ns.
  always #4 clk = ~clk;

  // Compare one value; an unknown never counts as a match.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // One APB transfer; request is held until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    rdat = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      n_errors++;
      give_verdict();
    end
  endtask

  // Let registered outputs land, then look at them mid-cycle.
  task automatic settle();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic t_interlock();
    apb(1'b1, `DCA_CFG_ADDR, 32'h18);
    apb(1'b1, `DCA_MASK_ADDR, 32'h1);
    term_run <= 2'h2;
    settle(); chk(run_out, 2'h2);
    @(posedge clk); stop_key <= 1'b1;
    @(posedge clk); stop_key <= 1'b0;
    settle(); chk(run_out, 2'h0);
    chk(err_code, `DCA_ERR_CODE);
    @(posedge clk); term_run <= 2'h0;
    settle();
    @(posedge clk); term_run <= 2'h2;
    settle(); chk(run_out, 2'h2);
    @(posedge clk); alarm_reset <= 1'b1;
    @(posedge clk); alarm_reset <= 1'b0;
    settle(); chk(run_out, 2'h0);
    chk(err_code, `DCA_ERR_CODE);
    chk(irq, 1'b1);
    @(posedge clk); term_run <= 2'h0;
    settle();
    @(posedge clk); term_run <= 2'h2;
    settle(); chk(run_out, 2'h2);
    apb(1'b0, `DCA_EVENT_ADDR, 32'h0); chk(rdat, 32'h5);
    apb(1'b0, `DCA_EVENT_ADDR, 32'h0); chk(rdat, 32'h0);
    term_run <= 2'h0;
    settle(); chk(irq, 1'b0);
    $display("Test interlock done");
  endtask

  task automatic t_link();
    @(posedge clk);
    want_freq <= 16'h1234;
    term_freq <= 16'h0100;
    for (int s = 0; s < 4; s++)
    begin
      apb(1'b1, `DCA_CFG_ADDR, 32'(s));
      link_enable_input <= 1'b1;
      settle(); chk({link_freq_grant, link_oper_grant}, {s[0], s[1]});
      chk(freq_out, s[0] ? 32'h1234 : 32'h0100);
      @(posedge clk); link_enable_input <= 1'b0;
      settle(); chk({link_freq_grant, link_oper_grant}, 2'h0);
      chk(freq_out, 32'h0100);
    end
    apb(1'b1, `DCA_CFG_ADDR, 32'h13);
    want_run <= 2'h2;
    settle(); chk(run_out, 2'h0);
    @(posedge clk); link_enable_input <= 1'b1;
    settle(); chk(run_out, 2'h0);
    chk(err_code, `DCA_ERR_CODE);
    @(posedge clk); want_run <= 2'h0;
    settle();
    @(posedge clk); want_run <= 2'h2;
    settle(); chk(run_out, 2'h2);
    @(posedge clk); stop_key <= 1'b1;
    @(posedge clk); stop_key <= 1'b0;
    settle(); chk(run_out, 2'h2);
    @(posedge clk); want_run <= 2'h0;
    settle();
    @(posedge clk); link_enable_input <= 1'b0;
    $display("Test link done");
  endtask

  task automatic t_decel();
    apb(1'b1, `DCA_CFG_ADDR, 32'h4);
    bus_over_level <= 1'b1;
    settle(); chk(decel_mode, DCA_DEC_REGEN);
    chk(torque_div, 2'h3);
    @(posedge clk); bus_over_level <= 1'b0;
    apb(1'b1, `DCA_CFG_ADDR, 32'h0);
    apb(1'b1, `DCA_DECEL_ADDR, 32'h64);
    apb(1'b1, `DCA_FLOOR_ADDR, 32'h258);
    term_freq <= 16'h0010;
    temp_alarm_level <= 1'b1;
    settle(); chk(decel_mode, DCA_DEC_RATE);
    chk(decel_rate, 32'h64);
    chk(freq_out, 32'h258);
    apb(1'b1, `DCA_DECEL_ADDR, 32'h0);
    settle(); chk(decel_mode, DCA_DEC_TIMES);
    apb(1'b1, `DCA_DECEL_ADDR, 32'h9B1C);
    settle(); chk(decel_mode, DCA_DEC_NORMAL);
    apb(1'b1, `DCA_DECEL_ADDR, 32'h64);
    apb(1'b1, `DCA_CFG_ADDR, 32'h120);
    settle(); chk(decel_mode, DCA_DEC_NORMAL);
    apb(1'b1, `DCA_CFG_ADDR, 32'h100);
    settle(); chk(decel_mode, DCA_DEC_RATE);
    @(posedge clk); temp_alarm_level <= 1'b0;
    regen_overenergy <= 1'b1;
    jog_active <= 1'b1;
    settle(); chk(output_off, 1'b1);
    chk(ramp_time, 32'h3E8);
    @(posedge clk); regen_overenergy <= 1'b0;
    $display("Test decel done");
  endtask

  task automatic t_regs();
    apb(1'b0, `DCA_EVENT_ADDR, 32'h0); chk(rdat, 32'hB);
    apb(1'b0, `DCA_STATUS_ADDR, 32'h0); chk(rdat, 32'h8);
    apb(1'b0, `DCA_JOG_ADDR, 32'h0); chk(rdat, 32'h3E8);
    apb(1'b1, `DCA_DECEL_ADDR, 32'h2711);
    apb(1'b0, `DCA_DECEL_ADDR, 32'h0); chk(rdat, 32'h9B1C);
    apb(1'b1, `DCA_FLOOR_ADDR, 32'h300);
    apb(1'b0, `DCA_FLOOR_ADDR, 32'h0); chk(rdat, 32'h258);
    apb(1'b1, 12'h040, 32'h1);
    chk(perr, 1'b1);
    $display("Test registers done");
  endtask

  // Reset again with a terminal run held: the power-up check must refuse it.
  task automatic t_powerup();
    @(posedge clk);
    sys_rst <= 1'b1;
    term_run <= 2'h2;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    settle(); chk(run_out, 2'h0);
    chk(err_code, `DCA_ERR_CODE);
    @(posedge clk); term_run <= 2'h0;
    settle();
    @(posedge clk); term_run <= 2'h2;
    settle(); chk(run_out, 2'h2);
    @(posedge clk); term_run <= 2'h0;
    term_is_source <= 1'b0;
    key_run <= 2'h2;
    key_freq <= 16'h0200;
    settle(); chk(run_out, 2'h2);
    chk(freq_out, 32'h200);
    @(posedge clk); key_run <= 2'h0;
    term_is_source <= 1'b1;
    $display("Test power-up done");
  endtask

  // Every bench-driven input has a value at time zero; reset is held for 12 cycles.
  initial
  begin
    clk = 1'b0; sys_rst = 1'b1; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
    link_enable_input = 1'b0; term_is_source = 1'b1; stop_key = 1'b0;
    alarm_reset = 1'b0; regen_overenergy = 1'b0; bus_over_level = 1'b0;
    temp_alarm_level = 1'b0; limiter_acting = 1'b0; jog_active = 1'b0;
    term_freq = 16'h0000; key_freq = 16'h0000; want_freq = 16'h0000;
    term_run = 2'h0; key_run = 2'h0; want_run = 2'h0;
    n_errors = 0; n_checks = 0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    t_interlock();
    t_link();
    t_decel();
    t_regs();
    t_powerup();
    give_verdict();
  end
endmodule
